// ---- hw/msg_defines.svh ----
// Timing, address and field constants for the monitor security gate.
`ifndef MSG_DEFINES_SVH
`define MSG_DEFINES_SVH
`define MSG_BIT_CYCLES     16'd256
`define MSG_KEY_BYTES      4'd8
`define MSG_KEY_BASE       16'hfff6
`define MSG_KEY_LAST       16'hfffd
`define MSG_BLANK_BYTE     8'hff
`define MSG_BAD_READ       8'h00
`define MSG_PASS_ADDR      16'h0040
`define MSG_PASS_BIT       3
`define MSG_PASS_BIT_VAL   3'd6
`define MSG_BREAK_BITS     4'd10
`define MSG_FRAME_BITS     4'd10
`define MSG_FLASH_LO       16'hc000
`define MSG_FIFO_DEPTH     16
`endif

// ---- hw/msg_pkg.sv ----
// Types shared by the monitor security gate files.
`default_nettype none
package msg_pkg;
  typedef enum logic [2:0] {
    MSG_RX_IDLE, MSG_RX_START, MSG_RX_DATA, MSG_RX_STOP
  } msg_rx_e;
  typedef enum logic [2:0] {
    MSG_TX_IDLE, MSG_TX_GAP, MSG_TX_SHIFT
  } msg_tx_e;
  typedef struct packed {
    logic       is_break;
    logic [7:0] data;
  } msg_txw_s;
endpackage
`default_nettype wire

// ---- hw/msg_fifo.sv ----
// Parameterised valid/ready FIFO with registered read data.
`timescale 1ns/1ps
`default_nettype none
module msg_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             full;
  logic             empty;
  logic             pop;

  // Full and empty come from the extra pointer bit.
  assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty     = (wp_r == rp_r);
  assign in_ready  = !full;
  assign pop       = !empty && (!out_valid || out_ready);

  // Storage array.
  always_ff @(posedge ref_clk)
  begin
    if (in_valid && !full)
    begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (in_valid && !full)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  // Output register keeps read data out of the array.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      out_data  <= '0;
      out_valid <= 1'b0;
    end
    else if (pop)
    begin
      out_data  <= mem_r[rp_r[AW-1:0]];
      out_valid <= 1'b1;
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end
endmodule // msg_fifo
`default_nettype wire

// ---- hw/msg_gate.sv ----
// Monitor security gate: key receive, compare, unlock, flash gating, echo and break.
//
// Functional notes
// R1: Eight host key bytes must all equal stored key bytes to unlock.
// R2: After power-on, wait for all eight key bytes before accepting commands.
// R3: A matching key allows all flash reads and flash fetches.
// R4: Unlock persists through every reset except power-on reset.
// R5: Non power-on resets need no new key and keep unlock state.
// R6: Locked after mismatch, flash reads return an invalid value.
// R7: Locked, a flash instruction fetch raises an illegal address reset; the code traps only once key_done is set.
// R8: Break character is sent only after all eight key bytes arrive; the code also echoes a received break as a break frame at any time.
// R9: Pass flag at bit six of low RAM byte shows correct key.
// R10: Mass erase leaves all eight key bytes at blank value.
// R11: After failure the host should power-cycle before retrying.
// R12: After failure the host may run a RAM mass-erase routine.
// R13: Users should program all key bytes with non-blank data.
// R14: A break is a zero start bit plus nine more zero bits.
// R15: Link framing is NRZ mark/space with equal rates both ways.
// R16: Each serial bit lasts 256 bus clock cycles.
// R17: Every received byte is echoed on the monitor serial pin.
// R18: Bytes compare in arrival order against ascending key addresses.
// R19: A sticky unlock flag gates flash read data and fetch permission.
`include "msg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module msg_gate (
  input  wire logic        ref_clk,
  input  wire logic        rst,           // Power-on reset only.
  input  wire logic        sys_reset,     // Any other reset, one-cycle pulse.
  input  wire logic        monitor_serial_pin_i,
  output logic             monitor_serial_pin_o,
  output logic             monitor_serial_pin_oe,
  input  wire logic        mass_erase,    // Pulse from the flash controller.
  input  wire logic [7:0]  key_byte_in,   // Stored key byte at key_addr.
  output logic [2:0]       key_addr,      // Offset from the key base.
  input  wire logic        flash_rd,
  input  wire logic [15:0] flash_addr,
  input  wire logic        flash_fetch,
  input  wire logic [7:0]  flash_raw,
  output logic [7:0]       flash_rdata,
  output logic             illegal_addr_rst,
  output logic             key_done,      // Commands may be accepted.
  output logic             unlocked,
  output logic [7:0]       pass_byte      // Image of the low RAM pass byte.
);
  // --------------------------------------------------------------
  // Two-flop input synchroniser
  // --------------------------------------------------------------
  logic rx_s1_r, rx_s2_r;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= monitor_serial_pin_i;
      rx_s2_r <= rx_s1_r;
    end
  end

  // --------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------
  msg_pkg::msg_rx_e rx_st_r;
  logic [15:0] rx_cnt_r;
  logic [3:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_stb;
  logic        rx_brk;
  // Samples mid-bit; a zero stop bit with zero data is a break.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_st_r  <= msg_pkg::MSG_RX_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 4'h0;
      rx_sh_r  <= 8'h00;
    end
    else
    begin
      unique case (rx_st_r)
        msg_pkg::MSG_RX_IDLE:
        begin
          rx_cnt_r <= 16'h0000;
          // The pin reads back our own drive, so a start edge is only taken while
          // the transmitter has let go; otherwise echoes would count as key bytes.
          if (!rx_s2_r && !monitor_serial_pin_oe) // R17
            rx_st_r <= msg_pkg::MSG_RX_START;
        end
        msg_pkg::MSG_RX_START:
        begin
          rx_cnt_r <= rx_cnt_r + 16'h0001;
          if (rx_cnt_r == (`MSG_BIT_CYCLES >> 1) - 16'h0001)
          begin
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_st_r  <= rx_s2_r ? msg_pkg::MSG_RX_IDLE : msg_pkg::MSG_RX_DATA;
          end
        end
        msg_pkg::MSG_RX_DATA:
        begin
          rx_cnt_r <= rx_cnt_r + 16'h0001;
          if (rx_cnt_r == `MSG_BIT_CYCLES - 16'h0001) // R16
          begin
            rx_cnt_r <= 16'h0000;
            rx_sh_r  <= {rx_s2_r, rx_sh_r[7:1]}; // R15
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h7)
              rx_st_r <= msg_pkg::MSG_RX_STOP;
          end
        end
        msg_pkg::MSG_RX_STOP:
        begin
          rx_cnt_r <= rx_cnt_r + 16'h0001;
          if (rx_cnt_r == `MSG_BIT_CYCLES - 16'h0001)
            rx_st_r <= msg_pkg::MSG_RX_IDLE;
        end
        default:
          rx_st_r <= msg_pkg::MSG_RX_IDLE;
      endcase
    end
  end
  assign rx_stb = (rx_st_r == msg_pkg::MSG_RX_STOP) &&
                  (rx_cnt_r == `MSG_BIT_CYCLES - 16'h0001);
  assign rx_brk = rx_stb && !rx_s2_r && (rx_sh_r == 8'h00); // R14

  // --------------------------------------------------------------
  // Key compare and sticky unlock
  // --------------------------------------------------------------
  logic [3:0] key_cnt_r;
  logic       key_ok_r;
  logic       unlock_r;
  logic       key_stb;
  assign key_addr = key_cnt_r[2:0]; // R18
  assign key_stb  = rx_stb && !rx_brk && (key_cnt_r != `MSG_KEY_BYTES);
  // Power-on only clears this; sys_reset is deliberately ignored so that
  // warm resets neither re-arm the key entry nor drop the unlock.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      key_cnt_r <= 4'h0; // R2
      key_ok_r  <= 1'b1;
      unlock_r  <= 1'b0;
    end
    else if (key_stb)
    begin
      key_cnt_r <= key_cnt_r + 4'h1;
      // Key bytes blanked by mass erase still compare as stored. R10
      if (rx_sh_r != key_byte_in)
        key_ok_r <= 1'b0; // R18
      if (key_cnt_r == `MSG_KEY_BYTES - 4'h1)
        unlock_r <= key_ok_r && (rx_sh_r == key_byte_in); // R1
    end
  end
  assign key_done = (key_cnt_r == `MSG_KEY_BYTES); // R2 R5
  assign unlocked = unlock_r; // R4 R5

  // --------------------------------------------------------------
  // Flash gating
  // --------------------------------------------------------------
  logic in_flash;
  assign in_flash = (flash_addr >= `MSG_FLASH_LO);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      flash_rdata      <= 8'h00;
      illegal_addr_rst <= 1'b0;
      pass_byte        <= 8'h00;
    end
    else
    begin
      if (flash_rd)
        flash_rdata <= (unlock_r || !in_flash) ? flash_raw : `MSG_BAD_READ; // R3 R6 R19
      illegal_addr_rst <= flash_fetch && in_flash && !unlock_r && key_done; // R7 R19
      pass_byte <= {1'b0, unlock_r, 6'h00}; // R9
    end
  end

  // --------------------------------------------------------------
  // Transmit queue: echoes and the post-key break
  // --------------------------------------------------------------
  msg_pkg::msg_txw_s push_w;
  msg_pkg::msg_txw_s pop_w;
  logic push_v, push_rdy, pop_v, pop_rdy;
  logic brk_due_r;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      brk_due_r <= 1'b0;
    else if (key_stb && key_cnt_r == `MSG_KEY_BYTES - 4'h1)
      brk_due_r <= 1'b1; // R8
    else if (push_rdy && !rx_stb)
      brk_due_r <= 1'b0;
  end
  // Echo has priority; the break follows in the next free cycle.
  assign push_v = rx_stb || brk_due_r; // R17
  assign push_w = rx_stb ? msg_pkg::msg_txw_s'{is_break: rx_brk, data: rx_sh_r}
                         : msg_pkg::msg_txw_s'{is_break: 1'b1, data: 8'h00};

  msg_fifo #(.WIDTH(9), .DEPTH(`MSG_FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_data   (push_w),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .out_data  (pop_w),
    .out_valid (pop_v),
    .out_ready (pop_rdy)
  );

  // --------------------------------------------------------------
  // Transmitter: two bit gap, then start, data, stop on the shared pin
  // --------------------------------------------------------------
  msg_pkg::msg_tx_e tx_st_r;
  logic [15:0] tx_cnt_r;
  logic [3:0]  tx_bit_r;
  logic [9:0]  tx_sh_r;
  assign pop_rdy = (tx_st_r == msg_pkg::MSG_TX_IDLE) && (rx_st_r == msg_pkg::MSG_RX_IDLE);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_st_r  <= msg_pkg::MSG_TX_IDLE;
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 4'h0;
      tx_sh_r  <= 10'h3ff;
    end
    else
    begin
      tx_cnt_r <= tx_cnt_r + 16'h0001;
      unique case (tx_st_r)
        msg_pkg::MSG_TX_IDLE:
        begin
          tx_cnt_r <= 16'h0000;
          tx_bit_r <= 4'h0;
          if (pop_v && pop_rdy)
          begin
            // Break frame holds zero through the stop slot. R14
            tx_sh_r <= pop_w.is_break ? 10'h000 : {1'b1, pop_w.data, 1'b0};
            tx_st_r <= msg_pkg::MSG_TX_GAP;
          end
        end
        msg_pkg::MSG_TX_GAP:
          if (tx_cnt_r == (`MSG_BIT_CYCLES << 1) - 16'h0001)
          begin
            tx_cnt_r <= 16'h0000;
            tx_st_r  <= msg_pkg::MSG_TX_SHIFT;
          end
        msg_pkg::MSG_TX_SHIFT:
          if (tx_cnt_r == `MSG_BIT_CYCLES - 16'h0001) // R16
          begin
            tx_cnt_r <= 16'h0000;
            tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == `MSG_FRAME_BITS - 4'h1)
              tx_st_r <= msg_pkg::MSG_TX_IDLE;
          end
        default:
          tx_st_r <= msg_pkg::MSG_TX_IDLE;
      endcase
    end
  end
  // Drive through the gap and while shifting so the host owns the pin otherwise.
  assign monitor_serial_pin_oe = (tx_st_r != msg_pkg::MSG_TX_IDLE);
  assign monitor_serial_pin_o  = (tx_st_r == msg_pkg::MSG_TX_SHIFT) ? tx_sh_r[0] : 1'b1;
endmodule // msg_gate
`default_nettype wire

// ---- test/msg_gate_monitor.sv ----
// Concurrent checks on the ports of the monitor security gate.
`timescale 1ns/1ps
`default_nettype none
module msg_gate_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        sys_reset,
  input wire logic        monitor_serial_pin_o,
  input wire logic        monitor_serial_pin_oe,
  input wire logic        flash_rd,
  input wire logic [15:0] flash_addr,
  input wire logic        flash_fetch,
  input wire logic [7:0]  flash_raw,
  input wire logic [7:0]  flash_rdata,
  input wire logic        illegal_addr_rst,
  input wire logic        key_done,
  input wire logic        unlocked,
  input wire logic [7:0]  pass_byte
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [11:0] zero_run_r;
  // Longest echo low stretch is nine bits, so a longer one can only be a break.
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      zero_run_r <= 12'h000;
    else if (!(monitor_serial_pin_oe && !monitor_serial_pin_o))
      zero_run_r <= 12'h000;
    else if (zero_run_r != 12'hfff)
      zero_run_r <= zero_run_r + 12'h001;
  sequence gap_high_s;
    monitor_serial_pin_o [*8];
  endsequence
  sequence locked_fetch_s;
    flash_fetch && !unlocked && key_done && flash_addr >= 16'hc000;
  endsequence
  unlock_sticky_a: assert property (unlocked |=> unlocked)
    else $error("unlock state was lost without power-on reset");
  warm_keep_a: assert property (sys_reset |=> $stable(unlocked) && $stable(key_done))
    else $error("warm reset changed the gate state");
  unlock_cause_a: assert property (unlocked |-> key_done)
    else $error("unlocked before the key was complete");
  pass_set_a: assert property (unlocked [*3] |-> pass_byte[6])
    else $error("pass flag not shown while unlocked");
  locked_read_a: assert property (flash_rd && !unlocked && flash_addr >= 16'hc000
    |=> flash_rdata == 8'h00)
    else $error("locked flash read leaked data");
  open_read_a: assert property (flash_rd && (unlocked || flash_addr < 16'hc000)
    |=> flash_rdata == $past(flash_raw))
    else $error("permitted read returned wrong data");
  fetch_trap_a: assert property (locked_fetch_s |=> illegal_addr_rst)
    else $error("locked fetch did not trap");
  trap_cause_a: assert property (illegal_addr_rst |-> $past(flash_fetch) && !$past(unlocked))
    else $error("trap without a locked fetch");
  gap_first_a: assert property ($rose(monitor_serial_pin_oe) |-> gap_high_s)
    else $error("reply did not open with a high gap");
  break_late_a: assert property (zero_run_r > 12'd2400 |-> key_done)
    else $error("break sent before the key was complete");
endmodule // msg_gate_monitor
`default_nettype wire

// ---- test/msg_host_model.sv ----
// Behavioural debug host on the one-wire monitor link.
`timescale 1ns/1ps
`default_nettype none
module msg_host_model (
  input  wire logic ref_clk,
  input  wire logic line,
  output logic      host_oe,
  output logic      host_o
);
  // ----------------------------------------
  // Link tasks
  // ----------------------------------------
  localparam int BIT = 256;
  // The host lets go between frames so the pull-up holds the line high.
  initial
  begin
    host_oe = 1'b0;
    host_o  = 1'b1;
  end
  // Sends one NRZ frame, start bit first, data LSB first; call just after a rising edge.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      host_oe <= 1'b1;
      host_o  <= fr[i];
      repeat (BIT) @(posedge ref_clk);
    end
    host_oe <= 1'b0;
  endtask
  // Samples one frame mid-bit and returns at the end of its stop slot.
  task automatic get_frame(output logic [9:0] fr);
    int n;
    n  = 0;
    fr = '1;
    while (line !== 1'b0 && n < 6000)
    begin
      @(negedge ref_clk);
      n++;
    end
    repeat (BIT / 2) @(negedge ref_clk);
    for (int i = 0; i < 10; i++)
    begin
      fr[i] = line;
      if (i < 9)
        repeat (BIT) @(negedge ref_clk);
    end
    repeat (BIT / 2) @(negedge ref_clk);
  endtask
endmodule // msg_host_model
`default_nettype wire

// ---- test/msg_gate_bench.sv ----
// Self-checking bench for the monitor security gate.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module msg_gate_bench;
  logic        ref_clk, rst, sys_reset, mass_erase, flash_rd, flash_fetch;
  logic [15:0] flash_addr;
  logic [7:0]  flash_raw, flash_rdata, pass_byte;
  logic [2:0]  key_addr;
  logic        pin_o, pin_oe, host_oe, host_o, key_done, unlocked, illegal_addr_rst;
  logic [7:0]  key_mem [8] = '{8'h3c, 8'ha5, 8'h5a, 8'h17, 8'he2, 8'h71, 8'h0f, 8'hc3};
  int          total_checks = 0;
  int          n_mismatch = 0;
  // The pin has a pull-up, so it is low only while someone drives a zero.
  wire         line = ~((pin_oe & ~pin_o) | (host_oe & ~host_o));
  wire  [7:0]  key_byte_in = key_mem[key_addr];
  msg_gate DUT (.ref_clk(ref_clk), .rst(rst), .sys_reset(sys_reset),
    .monitor_serial_pin_i(line), .monitor_serial_pin_o(pin_o), .monitor_serial_pin_oe(pin_oe),
    .mass_erase(mass_erase), .key_byte_in(key_byte_in), .key_addr(key_addr),
    .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_fetch(flash_fetch),
    .flash_raw(flash_raw), .flash_rdata(flash_rdata), .illegal_addr_rst(illegal_addr_rst),
    .key_done(key_done), .unlocked(unlocked), .pass_byte(pass_byte));
  msg_host_model host (.ref_clk(ref_clk), .line(line), .host_oe(host_oe), .host_o(host_o));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic power_on;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    `CHK({key_done, unlocked, pin_oe}, 3'b000)
  endtask
  // Byte three is spoiled by mask so one wrong position must fail the key.
  task automatic key_entry(input logic [7:0] mask);
    logic [9:0] fr;
    logic [7:0] b;
    for (int i = 0; i < 8; i++)
    begin
      b = key_mem[i] ^ ((i == 3) ? mask : 8'h00);
      repeat (256) @(posedge ref_clk);
      host.send_byte(b);
      host.get_frame(fr);
      `CHK(fr, {1'b1, b, 1'b0})
      `CHK(key_done, (i == 7))
    end
    host.get_frame(fr);
    `CHK(fr, 10'h000)
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] raw, input logic [7:0] exp);
    @(posedge ref_clk);
    flash_rd   <= 1'b1;
    flash_addr <= a;
    flash_raw  <= raw;
    @(posedge ref_clk);
    flash_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(flash_rdata, exp)
  endtask
  task automatic fetch(input logic [15:0] a, input logic exp);
    @(posedge ref_clk);
    flash_fetch <= 1'b1;
    flash_addr  <= a;
    @(posedge ref_clk);
    flash_fetch <= 1'b0;
    @(negedge ref_clk);
    `CHK(illegal_addr_rst, exp)
  endtask
  task automatic good_key;
    power_on();
    key_entry(8'h00);
    `CHK({unlocked, pass_byte}, 9'h140)
    rd(16'hfff6, 8'h3c, 8'h3c);
    rd(16'hc000, 8'h81, 8'h81);
    fetch(16'he000, 1'b0);
    @(posedge ref_clk);
    sys_reset <= 1'b1;
    @(posedge ref_clk);
    sys_reset <= 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK({unlocked, key_done}, 2'b11)
  endtask
  task automatic bad_key;
    power_on();
    key_entry(8'h10);
    `CHK({key_done, unlocked, pass_byte}, 10'h200)
    rd(16'hc000, 8'h81, 8'h00);
    rd(16'hfffd, 8'h42, 8'h00);
    rd(16'h0040, 8'h42, 8'h42);
    fetch(16'hc000, 1'b1);
    fetch(16'hbfff, 1'b0);
    @(posedge ref_clk);
    mass_erase <= 1'b1;
    key_mem = '{default: 8'hff};
    @(posedge ref_clk);
    mass_erase <= 1'b0;
    @(negedge ref_clk);
    `CHK(unlocked, 1'b0)
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // All inputs get a value at time zero, before the first edge.
  initial
  begin
    {rst, sys_reset, mass_erase, flash_rd, flash_fetch} = 5'b10000;
    flash_addr = 16'h0000;
    flash_raw  = 8'h00;
    good_key();
    bad_key();
    wrap_up();
  end
  // Two key runs take about 98k cycles; a short margin keeps a stuck run bounded.
  initial
  begin
    repeat (102000) @(posedge ref_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule // msg_gate_bench
bind msg_gate msg_gate_monitor mon (.ref_clk, .rst, .sys_reset, .monitor_serial_pin_o,
  .monitor_serial_pin_oe, .flash_rd, .flash_addr, .flash_fetch, .flash_raw, .flash_rdata,
  .illegal_addr_rst, .key_done, .unlocked, .pass_byte);
`default_nettype wire
